// ---- cnc_clock_network_control.sv ----
`timescale 1ns/10ps
module cnc_clock_network_control #(
    parameter int N_PLL = cnc_pkg::NUM_PLL_OUT
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // Clock sources
    input wire logic [cnc_pkg::NUM_PINS-1:0] CLK_PIN,
    input wire logic [N_PLL-1:0] PLL_CLK,
    input wire logic [cnc_pkg::NUM_GLOBAL-1:0] INT_CLK_GLOBAL,
    input wire logic [cnc_pkg::NUM_REGIONAL-1:0] INT_CLK_REGIONAL,
    // Static configuration, taken once after reset
    input wire cnc_pkg::cnc_cfg_type [cnc_pkg::NUM_GLOBAL-1:0] CFG_GLOBAL,
    input wire cnc_pkg::cnc_cfg_type [cnc_pkg::NUM_REGIONAL-1:0] CFG_REGIONAL,
    // Run-time control from user logic
    input wire logic [cnc_pkg::NUM_GLOBAL-1:0] GLOBAL_EN,
    input wire logic [cnc_pkg::NUM_GLOBAL-1:0][cnc_pkg::SEL_W-1:0] GLOBAL_SEL,
    input wire logic [cnc_pkg::NUM_REGIONAL-1:0] REGIONAL_EN,
    input wire logic [N_PLL-1:0] PLL_OUT_EN,
    // Gated networks
    output logic [cnc_pkg::NUM_GLOBAL-1:0] GLOBAL_NET,
    output logic [cnc_pkg::NUM_REGIONAL-1:0] REGIONAL_NET,
    output logic [N_PLL-1:0] PLL_OUT_PIN,
    output logic [cnc_pkg::NUM_QUAD-1:0][cnc_pkg::CLOCKS_PER_QUAD-1:0] QUAD_CLOCKS
);
    import cnc_pkg::*;

    // Cell numbering: globals first, then regionals, then PLL output pins
    localparam int N_CELL = NUM_GLOBAL + NUM_REGIONAL + N_PLL;
    // Offsets into the per-cell arrays
    localparam int R_BASE = NUM_GLOBAL;
    localparam int P_BASE = NUM_GLOBAL + NUM_REGIONAL;

    // Source picked by a select code; internal logic only by static choice
    // One function, so current and requested levels decode alike
    // Two-bit index matches the four selectable inputs
    function automatic logic pick(input cnc_src_type s, input logic internal,
                                  input logic [1:0] sel);
        pick = internal ? s.int_clk : s.inclk[sel];
    endfunction

    // Reset synchroniser
    logic [1:0] rst_sync_q;
    logic rst_n;

    // Configuration capture
    logic cfg_loaded_q;
    cnc_cfg_type cfg_in [N_CELL];
    cnc_cfg_type cfg_q [N_CELL];

    // Per-cell views of the shared ports
    cnc_src_type src_all [N_CELL];
    logic en_req [N_CELL];
    logic [1:0] sel_req [N_CELL];
    logic dyn_sel [N_CELL];

    // Gated nets, each bit driven by its own cell only
    logic [N_CELL-1:0] net_vec;

    // Reset release through two flops
    // Assertion stays asynchronous; only the release is retimed
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'h1};
        end
    end
    // Retimed release the rest of the logic waits for; assertion still comes from NRST
    assign rst_n = rst_sync_q[1];

    // Global cells: even pin on input zero, odd on one, two PLL taps
    // Pin pairing is fixed wiring, so a mis-routed pin cannot be chosen
    for (genvar g = 0; g < NUM_GLOBAL; g++) begin : g_glob
        // Pin pairs repeat every eight globals
        localparam int PIN_E = 2 * (g % (NUM_PINS / 2));

        // Selectable inputs
        assign src_all[g].inclk[SEL_PIN_EVEN] = CLK_PIN[PIN_E];
        assign src_all[g].inclk[SEL_PIN_ODD] = CLK_PIN[PIN_E + 1];
        assign src_all[g].inclk[SEL_PLL_A] = PLL_CLK[g % N_PLL];
        assign src_all[g].inclk[SEL_PLL_B] = PLL_CLK[(g + 1) % N_PLL];
        assign src_all[g].int_clk = INT_CLK_GLOBAL[g];

        // Static and run-time control
        assign cfg_in[g] = CFG_GLOBAL[g];
        assign en_req[g] = GLOBAL_EN[g];
        assign sel_req[g] = GLOBAL_SEL[g];
        assign dyn_sel[g] = 1'h1;
    end

    // Regional cells: pins of their own side, eight cells per quadrant
    // Select request tied off: the source comes from configuration alone
    for (genvar r = 0; r < NUM_REGIONAL; r++) begin : g_reg
        // Each quadrant owns a contiguous run of regional cells
        // and alternates between the two pin pairs of its side
        localparam int QUAD = r / REG_PER_QUAD;
        localparam int PIN_E = QUAD * PINS_PER_SIDE + 2 * (r % 2);

        // Selectable inputs
        assign src_all[R_BASE + r].inclk[SEL_PIN_EVEN] = CLK_PIN[PIN_E];
        assign src_all[R_BASE + r].inclk[SEL_PIN_ODD] = CLK_PIN[PIN_E + 1];
        assign src_all[R_BASE + r].inclk[SEL_PLL_A] = PLL_CLK[r % N_PLL];
        assign src_all[R_BASE + r].inclk[SEL_PLL_B] = PLL_CLK[(r + 1) % N_PLL];
        assign src_all[R_BASE + r].int_clk = INT_CLK_REGIONAL[r];

        // Static and run-time control
        assign cfg_in[R_BASE + r] = CFG_REGIONAL[r];
        assign en_req[R_BASE + r] = REGIONAL_EN[r];
        assign sel_req[R_BASE + r] = 2'h0;
        assign dyn_sel[R_BASE + r] = 1'h0;
    end

    // PLL output pin cells: gate only, PLL itself is left untouched
    // Every input carries the same tap, so the select code has no effect
    for (genvar p = 0; p < N_PLL; p++) begin : g_pll
        assign src_all[P_BASE + p].inclk = {NUM_INCLK{PLL_CLK[p]}};
        assign src_all[P_BASE + p].int_clk = 1'h0;

        // Always used, enabled only from user logic
        assign cfg_in[P_BASE + p] = CFG_PLL_OUT;
        assign en_req[P_BASE + p] = PLL_OUT_EN[p];
        assign sel_req[P_BASE + p] = 2'h0;
        assign dyn_sel[P_BASE + p] = 1'h0;
    end

    // Configuration is sampled once, on the first edge after the retimed release
    // Later changes wait for the next reset, as a reload would
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            cfg_loaded_q <= 1'h0;
        end else if (rst_n) begin
            cfg_loaded_q <= 1'h1;
        end
    end

    // One control cell per network
    for (genvar c = 0; c < N_CELL; c++) begin : g_cell
        // Registered state
        logic en_q;
        logic [1:0] sel_q;
        logic net_q;
        // Decoded levels and next values
        logic [1:0] sel_d;
        logic cur_lvl;
        logic new_lvl;
        logic low_phase;
        logic net_d;

        // Run-time select only on global cells, never onto internal logic
        assign sel_d = (dyn_sel[c] && !cfg_q[c].internal) ? sel_req[c] : cfg_q[c].src;

        // Level of the source in use and of the one asked for
        assign cur_lvl = pick(src_all[c], cfg_q[c].internal, sel_q);
        assign new_lvl = pick(src_all[c], cfg_q[c].internal, sel_d);

        // Swapping while either source is high could cut a pulse short
        // Limitation: a source held high delays the swap indefinitely
        assign low_phase = !cur_lvl && !new_lvl;

        // Unused or disabled nets sit low, so fed logic sees no edges
        // Config gate first: a cell not yet loaded stays dark
        assign net_d = cfg_loaded_q && cfg_q[c].used && en_q && cur_lvl;

        // Static configuration, held until the next reset
        // Reset value marks the cell unused, so the net stays dark until capture
        always_ff @(posedge CLK_SYS or negedge NRST) begin
            if (!NRST) begin
                cfg_q[c] <= CFG_RESET;
            end else if (rst_n && !cfg_loaded_q) begin
                cfg_q[c] <= cfg_in[c];
            end
        end

        // Enable and select move only while the source in use is low
        // Enable waits for a low source, so the last pulse ends whole
        always_ff @(posedge CLK_SYS or negedge NRST) begin
            if (!NRST) begin
                en_q <= 1'h0;
                sel_q <= 2'h0;
            end else if (rst_n && cfg_loaded_q) begin
                if (!cur_lvl) begin
                    en_q <= en_req[c];
                end
                if (low_phase) begin
                    sel_q <= sel_d;
                end
            end
        end

        // Net register; one cycle of latency buys a glitch-free output
        always_ff @(posedge CLK_SYS or negedge NRST) begin
            if (!NRST) begin
                net_q <= 1'h0;
            end else begin
                net_q <= rst_n && net_d;
            end
        end
        assign net_vec[c] = net_q;
    end

    // Network outputs
    // Global nets reach every quadrant unchanged
    assign GLOBAL_NET = net_vec[NUM_GLOBAL-1:0];
    assign REGIONAL_NET = net_vec[P_BASE-1:R_BASE];
    assign PLL_OUT_PIN = net_vec[N_CELL-1:P_BASE];

    // Each quadrant sees every global net plus its own regional ones
    // Regional nets stay within their own quadrant
    for (genvar q = 0; q < NUM_QUAD; q++) begin : g_quad
        assign QUAD_CLOCKS[q] = {REGIONAL_NET[q*REG_PER_QUAD +: REG_PER_QUAD],
                                 GLOBAL_NET};
    end

endmodule

// ---- cnc_clock_network_control_assertions.sv ----
`timescale 1ns/10ps
module cnc_chk import cnc_pkg::*; #(parameter int N_PLL = 8) (
    // Clock, reset, sources
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic [NUM_PINS-1:0] CLK_PIN,
    input wire logic [N_PLL-1:0] PLL_CLK,
    input wire logic [NUM_GLOBAL-1:0] INT_CLK_GLOBAL,
    // Configuration and control
    input wire cnc_cfg_type [NUM_GLOBAL-1:0] CFG_GLOBAL,
    input wire cnc_cfg_type [NUM_REGIONAL-1:0] CFG_REGIONAL,
    input wire logic [NUM_GLOBAL-1:0] GLOBAL_EN,
    input wire logic [NUM_GLOBAL-1:0][SEL_W-1:0] GLOBAL_SEL,
    input wire logic [NUM_REGIONAL-1:0] REGIONAL_EN,
    input wire logic [N_PLL-1:0] PLL_OUT_EN,
    // Nets
    input wire logic [NUM_GLOBAL-1:0] GLOBAL_NET,
    input wire logic [NUM_REGIONAL-1:0] REGIONAL_NET,
    input wire logic [N_PLL-1:0] PLL_OUT_PIN,
    input wire logic [NUM_QUAD-1:0][CLOCKS_PER_QUAD-1:0] QUAD_CLOCKS
);
    logic sel_lvl;
    // Level of the source that global cell zero has been asked for
    assign sel_lvl = GLOBAL_SEL[0] == SEL_PIN_EVEN ? CLK_PIN[0] :
        GLOBAL_SEL[0] == SEL_PIN_ODD ? CLK_PIN[1] :
        GLOBAL_SEL[0] == SEL_PLL_A ? PLL_CLK[0] : PLL_CLK[1];
    // One domain; four cycles cover the wait for a low phase
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    a_pll_follow: assert property (PLL_OUT_EN[0] [*4] |=> PLL_OUT_PIN[0] == $past(PLL_CLK[0]))
        else $error("pll pin lost its source");
    a_pll_off: assert property ((!PLL_OUT_EN[0]) [*4] |=> !PLL_OUT_PIN[0])
        else $error("disabled pll pin toggles");
    a_sel_route: assert property ((GLOBAL_EN[0] && CFG_GLOBAL[0].used && !CFG_GLOBAL[0].internal
        && $stable(GLOBAL_SEL[0])) [*4] |=> GLOBAL_NET[0] == $past(sel_lvl))
        else $error("global net not on selected source");
    a_int_source: assert property ((GLOBAL_EN[1] && CFG_GLOBAL[1].used && CFG_GLOBAL[1].internal) [*4]
        |=> GLOBAL_NET[1] == $past(INT_CLK_GLOBAL[1])) else $error("internal source not used");
    a_reg_fixed: assert property ((REGIONAL_EN[0] && CFG_REGIONAL[0].used && CFG_REGIONAL[0].src == 2'h0) [*4]
        |=> REGIONAL_NET[0] == $past(CLK_PIN[0])) else $error("regional net off its source");
    a_unused_off: assert property (!CFG_GLOBAL[15].used |-> !GLOBAL_NET[15])
        else $error("unused global net active");
    a_quad_wire: assert property (QUAD_CLOCKS[1] == {REGIONAL_NET[15:8], GLOBAL_NET})
        else $error("quadrant clock set miswired");
    a_reset_low: assert property (disable iff (1'b0) !NRST |-> GLOBAL_NET == '0 && PLL_OUT_PIN == '0)
        else $error("nets active in reset");
    a_full_pulse: assert property ($rose(GLOBAL_NET[0]) |=> GLOBAL_NET[0])
        else $error("shortened pulse on global net");
endmodule
bind cnc_clock_network_control cnc_chk #(.N_PLL(N_PLL)) u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST),
    .CLK_PIN(CLK_PIN), .PLL_CLK(PLL_CLK), .INT_CLK_GLOBAL(INT_CLK_GLOBAL),
    .CFG_GLOBAL(CFG_GLOBAL), .CFG_REGIONAL(CFG_REGIONAL), .GLOBAL_EN(GLOBAL_EN),
    .GLOBAL_SEL(GLOBAL_SEL), .REGIONAL_EN(REGIONAL_EN), .PLL_OUT_EN(PLL_OUT_EN),
    .GLOBAL_NET(GLOBAL_NET), .REGIONAL_NET(REGIONAL_NET), .PLL_OUT_PIN(PLL_OUT_PIN),
    .QUAD_CLOCKS(QUAD_CLOCKS));

// ---- cnc_pkg.sv ----
package cnc_pkg;

    // Network counts
    localparam int NUM_GLOBAL = 16;
    localparam int NUM_REGIONAL = 32;
    localparam int NUM_QUAD = 4;
    localparam int REG_PER_QUAD = 8;
    localparam int CLOCKS_PER_QUAD = 24;
    localparam int NUM_PINS = 16;
    localparam int PINS_PER_SIDE = 4;
    localparam int NUM_PLL_OUT = 8;
    localparam int NUM_INCLK = 4;
    localparam int SEL_W = 2;

    // Selectable cell inputs
    localparam logic [1:0] SEL_PIN_EVEN = 2'h0;
    localparam logic [1:0] SEL_PIN_ODD = 2'h1;
    localparam logic [1:0] SEL_PLL_A = 2'h2;
    localparam logic [1:0] SEL_PLL_B = 2'h3;

    // Static configuration of one cell
    typedef struct packed {
        logic used;
        logic internal;
        logic [1:0] src;
    } cnc_cfg_type;

    localparam cnc_cfg_type CFG_RESET = '{used: 1'b0, internal: 1'b0, src: 2'h0};
    localparam cnc_cfg_type CFG_PLL_OUT = '{used: 1'b1, internal: 1'b0, src: 2'h0};

    // Candidate clock levels seen by one cell
    typedef struct packed {
        logic [3:0] inclk;
        logic int_clk;
    } cnc_src_type;

endpackage

// ---- cnc_src_model.sv ----
`timescale 1ns/10ps
module cnc_src_model import cnc_pkg::*; #(parameter int N_PLL = 8) (
    // Clock
    input wire logic CLK_SYS,
    // Source levels seen by the cells
    output logic [NUM_PINS-1:0] CLK_PIN,
    output logic [N_PLL-1:0] PLL_CLK,
    output logic [NUM_GLOBAL-1:0] INT_CLK_GLOBAL,
    output logic [NUM_REGIONAL-1:0] INT_CLK_REGIONAL
);
    logic [1:0] cnt_q = 2'h0;
    // Two cycles high, two low, so a gate change always finds a low phase
    always @(posedge CLK_SYS) cnt_q <= #1 cnt_q + 2'h1;
    // Odd pins held low so a switch to input one shows a flat net
    assign CLK_PIN = {(NUM_PINS / 2){1'b0, cnt_q[1]}};
    assign PLL_CLK = {N_PLL{cnt_q[1]}}; // Same level as the even pins, from the same counter bit
    assign INT_CLK_GLOBAL = {NUM_GLOBAL{~cnt_q[1]}};
    assign INT_CLK_REGIONAL = {NUM_REGIONAL{~cnt_q[1]}};
endmodule

// ---- tb_clock_network_control.sv ----
`timescale 1ns/10ps
module tb_clock_network_control;
    import cnc_pkg::*;
    logic clk_sys, nrst;
    logic [NUM_PINS-1:0] clk_pin;
    logic [7:0] pll_clk, p_en, p_pin;
    logic [NUM_GLOBAL-1:0] int_g, g_en, g_net;
    logic [NUM_REGIONAL-1:0] int_r, r_en, r_net;
    logic [NUM_GLOBAL-1:0][SEL_W-1:0] g_sel;
    cnc_cfg_type [NUM_GLOBAL-1:0] cfg_g;
    cnc_cfg_type [NUM_REGIONAL-1:0] cfg_r;
    logic [NUM_QUAD-1:0][CLOCKS_PER_QUAD-1:0] quad;
    int err_count = 0;
    int n_checks = 0;
    cnc_src_model src (.CLK_SYS(clk_sys), .CLK_PIN(clk_pin), .PLL_CLK(pll_clk),
        .INT_CLK_GLOBAL(int_g), .INT_CLK_REGIONAL(int_r));
    cnc_clock_network_control dut (.CLK_SYS(clk_sys), .NRST(nrst), .CLK_PIN(clk_pin),
        .PLL_CLK(pll_clk), .INT_CLK_GLOBAL(int_g), .INT_CLK_REGIONAL(int_r),
        .CFG_GLOBAL(cfg_g), .CFG_REGIONAL(cfg_r), .GLOBAL_EN(g_en), .GLOBAL_SEL(g_sel),
        .REGIONAL_EN(r_en), .PLL_OUT_EN(p_en), .GLOBAL_NET(g_net), .REGIONAL_NET(r_net),
        .PLL_OUT_PIN(p_pin), .QUAD_CLOCKS(quad));
    // System clock, 20 ns
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Set controls, let one low phase pass, then compare sample nets each cycle for eight cycles
    task automatic run(input string name, input logic en, input logic [1:0] sel);
        logic lvl, ilvl, rlvl;
        @(posedge clk_sys) #1;
        g_en = {NUM_GLOBAL{en}};
        r_en = {NUM_REGIONAL{en}};
        p_en = {8{en}};
        g_sel = {NUM_GLOBAL{sel}};
        repeat (6) @(posedge clk_sys);
        repeat (8) begin
            @(posedge clk_sys);
            lvl = clk_pin[0];
            ilvl = int_g[1];
            rlvl = int_r[1];
            #2;
            check("reg internal", r_net[1], en & rlvl);
            check("global", g_net[0], en & (sel != SEL_PIN_ODD) & lvl);
            check("internal", g_net[1], en & ilvl);
            check("regional", r_net[0], en & lvl);
            check("pll pin", p_pin[0], en & lvl);
            check("unused", {g_net[15], r_net[31]}, 32'h0);
            check("quad", quad[2], {r_net[23:16], g_net});
        end
        $display("test %s done", name);
    endtask
    // Enable every net on input zero
    task automatic test_enable();
        run("enable", 1'b1, SEL_PIN_EVEN);
    endtask
    // Walk the global select through the other three inputs
    task automatic test_select();
        for (int s = 1; s < 4; s++) run("select", 1'b1, s[1:0]);
    endtask
    // Switch every net off again
    task automatic test_disable();
        run("disable", 1'b0, SEL_PIN_EVEN);
    endtask
    // Hang guard
    initial begin
        #1000000;
        err_count++;
        results();
    end
    // Net 1 internal, last global and regional unused, rest on input zero
    initial begin
        nrst = 1'b0;
        {g_en, r_en, p_en, g_sel} = '0;
        for (int i = 0; i < NUM_GLOBAL; i++) cfg_g[i] = CFG_PLL_OUT;
        for (int i = 0; i < NUM_REGIONAL; i++) cfg_r[i] = CFG_PLL_OUT;
        cfg_g[1].internal = 1'b1;
        cfg_g[15] = CFG_RESET;
        cfg_r[31] = CFG_RESET;
        cfg_r[1].internal = 1'b1;
        repeat (12) @(posedge clk_sys);
        check("reset", {g_net, p_pin}, 32'h0);
        #1 nrst = 1'b1;
        test_enable();
        test_select();
        test_disable();
        results();
    end
endmodule
